// >>> keepalive_pkg.sv
// shared constants for the keep-alive frame scheduler
package keepalive_pkg;
  // timing: one interval unit is 20.48 ms, clock period 5 ns
  localparam int unsigned TICK_PERIOD_NS = 20480000;
  localparam int unsigned CLK_PERIOD_NS  = 5;
  localparam int unsigned TICK_CYCLES    = TICK_PERIOD_NS / CLK_PERIOD_NS;
  localparam int unsigned TICK_W         = 22;

  // register byte offsets
  localparam logic [7:0] OFS_CTRL     = 8'h00;
  localparam logic [7:0] OFS_MODE     = 8'h04;
  localparam logic [7:0] OFS_PERIOD   = 8'h08;
  localparam logic [7:0] OFS_PERIOD_B = 8'h0c;
  localparam logic [7:0] OFS_HEADER   = 8'h10;
  localparam logic [7:0] OFS_LENGTH   = 8'h14;
  localparam logic [7:0] OFS_DATA_LO  = 8'h18;
  localparam logic [7:0] OFS_DATA_HI  = 8'h1c;
  localparam logic [7:0] OFS_STORED   = 8'h20;
  localparam logic [7:0] OFS_STATUS   = 8'h24;

  // control, header and status register fields
  localparam int unsigned CTRL_PROTO_LSB  = 0;
  localparam int unsigned CTRL_ACTIVE_BIT = 4;
  localparam int unsigned CTRL_MON_BIT    = 5;
  localparam int unsigned CTRL_SILENT_BIT = 6;
  localparam int unsigned CTRL_GATE_BIT   = 8;
  localparam int unsigned HDR_EXT_BIT     = 31;
  localparam int unsigned ST_EN_BIT       = 0;
  localparam int unsigned ST_PEND_BIT     = 1;
  localparam int unsigned ST_MODE_LSB     = 2;
  localparam int unsigned ST_CNT_LSB      = 8;

  // encodings
  localparam logic [3:0] PROTO_NONE  = 4'h0;
  localparam logic [1:0] MODE_OFF    = 2'h0;
  localparam logic [1:0] MODE_ONE    = 2'h1;
  localparam logic [1:0] MODE_TWO    = 2'h2;
  localparam logic [7:0] STORED_ONE  = 8'h01;
  localparam logic [7:0] STORED_TWO  = 8'h02;
  localparam logic [7:0] PERIOD_OFF  = 8'h00;
  localparam logic [3:0] LEN_MAX     = 4'h8;
  localparam logic [28:0] ID11_MASK  = 29'h000007ff;

  // reset values; default id and payload are arbitrary neutral values
  localparam logic [7:0]  PERIOD_RST = 8'h62;
  localparam logic [7:0]  STORED_RST = 8'hff;
  localparam logic        GATE_RST   = 1'b1;
  localparam logic [28:0] ID_RST     = 29'h00000100;
  localparam logic [3:0]  LEN_RST    = 4'h8;
  localparam logic [31:0] DATA_LO_RST = 32'h00000000;
  localparam logic [31:0] DATA_HI_RST = 32'h00000000;
endpackage

// >>> tick_divider.sv
// divider that makes the 20.48 ms interval tick
`timescale 1ns/1ps
`default_nettype none
module tick_divider
  import keepalive_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
)(
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic run,
  input  wire logic clear,
  output logic      tick
);
  typedef struct packed {
    logic [TICK_W-1:0] cnt;
    logic              tick;
  } div_state_t;

  div_state_t s;
  div_state_t next_s;

  // count only while running so the phase restarts with every clear
  always_comb
  begin
    next_s = s;
    next_s.tick = 1'b0;
    if (clear || !run)
      next_s.cnt = '0;
    else if (s.cnt == TICK_W'(TICK_LEN - 1))
    begin
      next_s.cnt = '0;
      next_s.tick = 1'b1;
    end
    else
      next_s.cnt = s.cnt + TICK_W'(1);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      s <= '0;
    else
      s <= next_s;
  end

  assign tick = s.tick;
endmodule // tick_divider
`default_nettype wire

// >>> payload_store.sv
// two-word store for the keep-alive payload bytes
`timescale 1ns/1ps
`default_nettype none
module payload_store
  import keepalive_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        we,
  input  wire logic        waddr,
  input  wire logic [31:0] wdata,
  input  wire logic        re,
  input  wire logic        raddr,
  output logic [31:0]      rdata,
  output logic [63:0]      content
);
  typedef struct packed {
    logic [1:0][31:0] words;
    logic [31:0]      rdata;
  } mem_state_t;

  mem_state_t s;
  mem_state_t next_s;

  // write and registered read port
  always_comb
  begin
    next_s = s;
    if (we)
      next_s.words[waddr] = wdata;
    if (re)
      next_s.rdata = s.words[raddr];
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s.words[0] <= DATA_LO_RST;
      s.words[1] <= DATA_HI_RST;
      s.rdata    <= '0;
    end
    else
      s <= next_s;
  end

  assign rdata = s.rdata;
  assign content = s.words; // byte 0 in bits 7:0
endmodule // payload_store
`default_nettype wire

// >>> keepalive_sender.sv
// keep-alive frame scheduler with its apb register file
//
// Local design decisions: the register offsets and register access over APB.
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - a stored default mode of 01 or 02 alone never starts sending.
// - sending needs a protocol other than 0 in normal send/receive use.
// - monitoring mode blocks sending unless silent listening is off.
// - without a stored mode 1/2, host must pick mode 1 or 2 and go active.
// - gate off or period 00 blocks sending whatever else holds.
// - by default the frame has a built-in 11-bit id and 8 data bytes.
// - the frame always uses the id last loaded by the header command.
// - payload goes out as given, its length is the length register value capped at 8 bytes.
// - the interval is an 8-bit value in units of 20.48 ms, two commands.
// - after reset the period setting is 62 hex, about 2 seconds.
// - the period is a live compare value against the running counter.
// - counter clears on a mode write, on a period write only when idle.
// - sending is the and of protocol open, listen ok, mode, period and gate.
module keepalive_sender
  import keepalive_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
)(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        can_busy,
  input  wire logic        tx_ack,
  output logic             tx_req,
  output logic [28:0]      tx_id,
  output logic             tx_ext,
  output logic [3:0]       tx_dlc,
  output logic [63:0]      tx_data
);
  // frame sequencer states; the fourth code is never entered
  typedef enum logic [1:0] {st_idle, st_wait_bus, st_request} tx_state_t;

  // all state in one record, filled by one comb copy each cycle
  typedef struct packed {
    logic [3:0]  proto;
    logic        active;
    logic        monitor;
    logic        silent_off;
    logic        gate;
    logic        mode_set;
    logic [1:0]  mode;
    logic [7:0]  stored_mode;
    logic [7:0]  period;
    logic [28:0] id;
    logic        ext;
    logic [3:0]  len;
    logic [7:0]  count;
    tx_state_t   st;
    logic [31:0] rdata;
    logic        rd_mem;
    logic [28:0] tx_id;
    logic        tx_ext;
    logic [3:0]  tx_dlc;
    logic [63:0] tx_data;
  } ka_state_t;

  ka_state_t   s;
  ka_state_t   next_s;
  // decode, enable and sequencing terms
  logic        setup_rd;
  logic        wr;
  logic        hit;
  logic        is_data;
  logic        mem_we;
  logic [31:0] mem_rdata;
  logic [63:0] mem_content;
  logic [1:0]  eff_mode;
  logic        enabled;
  logic        proto_open;
  logic        listen_ok;
  logic        mode_on;
  logic        period_on;
  logic        acc;
  logic        rd_hi;
  logic        tick;
  logic        mode_wr;
  logic        period_wr;
  logic        clr_cnt;
  logic        due;
  logic [8:0]  cnt_inc;

  // bus decode; zero wait states, so a write lands in the access cycle
  assign acc = psel & penable;
  assign setup_rd = psel & ~penable & ~pwrite;
  assign wr = acc & pwrite;
  assign rd_hi = (paddr == OFS_DATA_HI);
  assign is_data = (paddr == OFS_DATA_LO) || (paddr == OFS_DATA_HI);
  assign hit = (paddr == OFS_CTRL) || (paddr == OFS_MODE)
            || (paddr == OFS_PERIOD) || (paddr == OFS_PERIOD_B)
            || (paddr == OFS_HEADER) || (paddr == OFS_LENGTH)
            || is_data || (paddr == OFS_STORED)
            || (paddr == OFS_STATUS);
  assign mem_we = wr & is_data;
  assign mode_wr = wr & (paddr == OFS_MODE);
  assign period_wr = wr & ((paddr == OFS_PERIOD)
                        || (paddr == OFS_PERIOD_B));

  // the stored default only stands in until the host picks a mode
  always_comb
  begin
    if (s.mode_set)
      eff_mode = s.mode;
    else if (s.stored_mode == STORED_ONE)
      eff_mode = MODE_ONE;
    else if (s.stored_mode == STORED_TWO)
      eff_mode = MODE_TWO;
    else
      eff_mode = MODE_OFF;
  end

  // the held conditions, kept apart so each one reads on its own
  assign proto_open = (s.proto != PROTO_NONE) && s.active;
  assign listen_ok = !s.monitor || s.silent_off;
  assign mode_on = (eff_mode == MODE_ONE)
                || (eff_mode == MODE_TWO);
  assign period_on = (s.period != PERIOD_OFF);
  // stored mode alone is never enough; the gate overrides everything
  assign enabled = proto_open && listen_ok && mode_on
                && period_on && s.gate;

  // restart timing on a mode pick; a period write mid-stream does not
  assign clr_cnt = mode_wr
                 | (period_wr & ~enabled) | ~enabled;
  assign cnt_inc = {1'b0, s.count} + 9'h001;
  // greater-or-equal so a shortened period still fires promptly
  assign due = enabled & tick
            & (cnt_inc >= {1'b0, s.period});

  // the divider stops while disabled so every enable starts a full tick
  tick_divider #(
    .TICK_LEN (TICK_LEN)
  ) u_tick (
    .pclk    (pclk),
    .presetn (presetn),
    .run     (enabled),
    .clear   (clr_cnt),
    .tick    (tick)
  );

  // payload words live in their own store with a registered read port
  payload_store u_payload (
    .pclk    (pclk),
    .presetn (presetn),
    .we      (mem_we),
    .waddr   (rd_hi),
    .wdata   (pwdata),
    .re      (setup_rd & is_data),
    .raddr   (rd_hi),
    .rdata   (mem_rdata),
    .content (mem_content)
  );

  // register writes, read capture, interval counter and frame sequencer
  always_comb
  begin
    next_s = s;
    if (wr)
    begin
      unique case (paddr)
        OFS_CTRL:
        begin
          next_s.proto = pwdata[CTRL_PROTO_LSB +: 4];
          next_s.active = pwdata[CTRL_ACTIVE_BIT];
          next_s.monitor = pwdata[CTRL_MON_BIT];
          next_s.silent_off = pwdata[CTRL_SILENT_BIT];
          next_s.gate = pwdata[CTRL_GATE_BIT];
        end
        OFS_MODE:
        begin
          next_s.mode = pwdata[1:0];
          next_s.mode_set = 1'b1;
        end
        OFS_PERIOD, OFS_PERIOD_B:
          next_s.period = pwdata[7:0];
        OFS_HEADER:
        begin
          next_s.ext = pwdata[HDR_EXT_BIT];
          next_s.id = pwdata[HDR_EXT_BIT] ? pwdata[28:0]
                    : (pwdata[28:0] & ID11_MASK);
        end
        OFS_LENGTH:
          next_s.len = (pwdata[3:0] > LEN_MAX) ? LEN_MAX
                     : pwdata[3:0];
        OFS_STORED:
          next_s.stored_mode = pwdata[7:0];
        default:
          next_s.len = s.len; // payload, status and unmapped
      endcase
    end

    // read data is captured in the setup cycle, ready in the access one
    if (setup_rd)
    begin
      next_s.rd_mem = is_data;
      unique case (paddr)
        OFS_CTRL:
        begin
          next_s.rdata = '0;
          next_s.rdata[CTRL_PROTO_LSB +: 4] = s.proto;
          next_s.rdata[CTRL_ACTIVE_BIT] = s.active;
          next_s.rdata[CTRL_MON_BIT] = s.monitor;
          next_s.rdata[CTRL_SILENT_BIT] = s.silent_off;
          next_s.rdata[CTRL_GATE_BIT] = s.gate;
        end
        OFS_MODE:
          next_s.rdata = {30'h00000000, s.mode};
        OFS_PERIOD, OFS_PERIOD_B:
          next_s.rdata = {24'h000000, s.period};
        OFS_HEADER:
          next_s.rdata = {s.ext, 2'h0, s.id};
        OFS_LENGTH:
          next_s.rdata = {28'h0000000, s.len};
        OFS_STORED:
          next_s.rdata = {24'h000000, s.stored_mode};
        OFS_STATUS:
        begin
          next_s.rdata = '0;
          next_s.rdata[ST_EN_BIT] = enabled;
          next_s.rdata[ST_PEND_BIT] = (s.st != st_idle);
          next_s.rdata[ST_MODE_LSB +: 2] = eff_mode;
          next_s.rdata[ST_CNT_LSB +: 8] = s.count;
        end
        default:
          next_s.rdata = '0;
      endcase
    end

    // interval counter
    if (clr_cnt)
      next_s.count = '0;
    else if (due)
      next_s.count = '0;
    else if (tick)
      next_s.count = cnt_inc[7:0];

    // one frame at most waits; it never cuts into bus traffic
    unique case (s.st)
      st_idle:
        if (due)
          next_s.st = st_wait_bus;
      st_wait_bus:
        if (!enabled)
          next_s.st = st_idle;
        else if (!can_busy)
        begin
          next_s.st = st_request;
          next_s.tx_id = s.id;
          next_s.tx_ext = s.ext;
          next_s.tx_dlc = s.len;
          next_s.tx_data = mem_content;
        end
      st_request:
        if (tx_ack)
          next_s.st = st_idle;
      default:
        next_s.st = st_idle; // unused code falls back to idle
    endcase
  end

  // reset loads the defaults; only constants in this branch
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s <= '0;
      s.gate <= GATE_RST;
      s.mode <= MODE_OFF;
      s.stored_mode <= STORED_RST;
      s.period <= PERIOD_RST;
      s.id <= ID_RST;
      s.len <= LEN_RST;
      s.st <= st_idle;
    end
    else
      s <= next_s;
  end

  // no wait states: every access ends in its first access cycle
  assign pready = 1'b1;
  assign pslverr = acc & ~hit;
  assign prdata = s.rd_mem ? mem_rdata : s.rdata;
  assign tx_req = (s.st == st_request);
  assign tx_id = s.tx_id;
  assign tx_ext = s.tx_ext;
  assign tx_dlc = s.tx_dlc;
  assign tx_data = s.tx_data;
endmodule // keepalive_sender
`default_nettype wire

// >>> keepalive_sender_assertions.sv
// port-level checker for the keep-alive frame scheduler
`timescale 1ns/1ps
`default_nettype none
module keepalive_sender_assertions
  import keepalive_pkg::*;
#(
  parameter int unsigned TICK_LEN = TICK_CYCLES
)(
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        can_busy,
  input wire logic        tx_ack,
  input wire logic        tx_req,
  input wire logic [28:0] tx_id,
  input wire logic        tx_ext,
  input wire logic [3:0]  tx_dlc,
  input wire logic [63:0] tx_data
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // cycles since reset, saturating; no frame can be due before one tick
  logic [31:0] since_rst;
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      since_rst <= '0;
    else if (since_rst != '1)
      since_rst <= since_rst + 32'h1;
  sequence s_offer;
    tx_req && !tx_ack;
  endsequence
  sequence s_taken;
    tx_req && tx_ack;
  endsequence
  chk_offer_hold: assert property (s_offer |=> tx_req)
    else $error("frame offer withdrawn early");
  chk_offer_end: assert property (s_taken |=> !tx_req)
    else $error("frame offer kept after ack");
  chk_wait_bus: assert property ($rose(tx_req) |-> !$past(can_busy))
    else $error("frame offered onto a busy bus");
  chk_id_hold: assert property (s_offer |=> $stable(tx_id) && $stable(tx_ext))
    else $error("frame id changed while offered");
  chk_data_hold: assert property (s_offer |=> $stable(tx_data) && $stable(tx_dlc))
    else $error("frame payload changed while offered");
  chk_dlc_limit: assert property (tx_req |-> tx_dlc <= LEN_MAX)
    else $error("frame length above eight");
  chk_short_id: assert property (tx_req && !tx_ext |-> tx_id[28:11] == 18'h0)
    else $error("short id has upper bits set");
  chk_tick_first: assert property (tx_req |-> since_rst > TICK_LEN)
    else $error("frame before first interval tick");
endmodule // keepalive_sender_assertions
bind keepalive_sender keepalive_sender_assertions #(.TICK_LEN(TICK_LEN)) u_chk (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
  .pslverr, .can_busy, .tx_ack, .tx_req, .tx_id, .tx_ext, .tx_dlc, .tx_data);
`default_nettype wire

// >>> can_ctrl_model.sv
// behavioural can controller that takes offered keep-alive frames
`timescale 1ns/1ps
`default_nettype none
module can_ctrl_model (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tx_req,
  input  wire logic hold_busy,
  input  wire logic slow,
  output logic      can_busy,
  output logic      tx_ack
);
  logic [3:0] wait_cnt;
  // bench holds the bus busy to stand in for a running exchange
  assign can_busy = hold_busy;
  // ack is a single pulse, only while a frame is offered; slow mode
  // stretches arbitration so the held-offer path is exercised
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      wait_cnt <= 4'h0;
      tx_ack   <= 1'b0;
    end
    else
    begin
      tx_ack <= 1'b0;
      if (tx_req && !tx_ack)
      begin
        wait_cnt <= wait_cnt + 4'h1;
        if (wait_cnt >= (slow ? 4'h6 : 4'h0))
        begin
          tx_ack   <= 1'b1;
          wait_cnt <= 4'h0;
        end
      end
    end
endmodule // can_ctrl_model
`default_nettype wire

// >>> tb_keepalive_sender.sv
// self-checking bench for the keep-alive frame scheduler
`timescale 1ns/1ps
`default_nettype none
module tb_keepalive_sender import keepalive_pkg::*;;
  localparam int unsigned TL = 8;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        can_busy, tx_ack, tx_req, tx_ext, hold_busy, slow;
  logic [28:0] tx_id;
  logic [3:0]  tx_dlc;
  logic [63:0] tx_data;
  logic [32:0] rd_q[$];
  logic [97:0] fr_q[$];
  int          num_errors, n_compared, n_frames;
  // gating table: write, then expected status
  logic [7:0]  g_addr[9] = '{OFS_CTRL, OFS_CTRL, OFS_CTRL, OFS_PERIOD,
    OFS_CTRL, OFS_MODE, OFS_PERIOD_B, OFS_MODE, OFS_CTRL};
  logic [11:0] g_data[9] = '{12'h133, 12'h173, 12'h073, 12'h000, 12'h173,
    12'h000, 12'h004, 12'h002, 12'h053};
  logic [7:0]  g_stat[9] = '{8'h04, 8'h05, 8'h04, 8'h04, 8'h04, 8'h00,
    8'h00, 8'h09, 8'h08};
  keepalive_sender #(.TICK_LEN(TL)) u_keepalive_sender (.pclk, .presetn,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .can_busy, .tx_ack, .tx_req, .tx_id, .tx_ext, .tx_dlc, .tx_data);
  can_ctrl_model u_can_ctrl_model (.pclk, .presetn, .tx_req, .hold_busy,
    .slow, .can_busy, .tx_ack);
  initial
  begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end
  function automatic logic [63:0] mask(input logic [3:0] n);
    return (n >= 4'h8) ? '1 : (64'h1 << (8 * n)) - 64'h1;
  endfunction
  task automatic chk_word(input logic [32:0] exp, input logic [32:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_frame(input logic [97:0] exp, input logic [97:0] got);
    n_compared++;
    if (got !== exp)
    begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // results are matched against the oldest note as they appear
  always @(posedge pclk)
  begin
    if (psel && penable && pready && !pwrite)
      chk_word(rd_q.pop_front(), {pslverr, prdata});
    if (tx_req && tx_ack)
    begin
      n_frames++;
      chk_frame(fr_q.size() ? fr_q.pop_front() : '1,
        {tx_ext, tx_id, tx_dlc, tx_data & mask(tx_dlc)});
    end
  end
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (!pready);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(a, 1'b1, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [32:0] exp);
    rd_q.push_back(exp);
    apb(a, 1'b0, 32'h0);
  endtask
  task automatic wait_frame(output int cyc);
    int n0;
    n0  = n_frames;
    cyc = 0;
    while (n_frames == n0 && cyc < 3000)
    begin
      @(posedge pclk);
      cyc++;
    end
  endtask
  // reload with the gate shut so a half-written frame never goes out
  task automatic frame(input logic [31:0] hdr, input logic [3:0] len,
                       input logic [63:0] d, input logic st,
                       input logic lv);
    logic [3:0] dl;
    int         cyc;
    dl = (len > LEN_MAX) ? LEN_MAX : len;
    wr(OFS_CTRL, 32'h53);
    wr(OFS_HEADER, hdr);
    wr(OFS_LENGTH, {28'h0, len});
    wr(OFS_DATA_LO, d[31:0]);
    wr(OFS_DATA_HI, d[63:32]);
    fr_q.push_back({hdr[31], hdr[31] ? hdr[28:0] : hdr[28:0] & ID11_MASK,
      dl, d & mask(dl)});
    hold_busy <= st;
    if (lv)
      wr(OFS_PERIOD, 32'h40);
    wr(OFS_CTRL, 32'h153);
    if (st)
    begin
      repeat (80) @(posedge pclk);
      hold_busy <= 1'b0;
    end
    // shorten a long period mid-stream: count kept, next tick fires
    if (lv)
    begin
      repeat (2 * TL + 4) @(posedge pclk);
      wr(OFS_PERIOD, 32'h2);
    end
    wait_frame(cyc);
    if (lv)
      chk_word(33'h1, {32'h0, cyc <= TL + 4});
    wr(OFS_CTRL, 32'h53);
    if (lv)
      wr(OFS_PERIOD, 32'h4);
    chk_word(33'h0, {1'b0, 32'(fr_q.size())});
  endtask
  task automatic results();
    $display("compared %0d, errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  initial
  begin
    repeat (60000) @(posedge pclk);
    num_errors++;
    results();
  end
  initial
  begin
    int cyc;
    {presetn, psel, penable, pwrite, hold_busy, slow} = '0;
    paddr      = 8'h0;
    pwdata     = 32'h0;
    num_errors = 0;
    n_compared = 0;
    n_frames   = 0;
    void'($urandom(63));
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CTRL, 33'h100);
    rd(OFS_PERIOD, 33'h62);
    rd(OFS_PERIOD_B, 33'h62);
    rd(OFS_HEADER, {4'h0, ID_RST});
    rd(OFS_LENGTH, 33'h8);
    rd(8'h28, 33'h1_0000_0000);
    $display("test reset values done");
    wr(OFS_STORED, 32'h1);
    wr(OFS_PERIOD, 32'h4);
    rd(OFS_STATUS, 33'h4);
    fr_q.push_back({1'b0, ID_RST, LEN_RST, DATA_HI_RST, DATA_LO_RST});
    wr(OFS_CTRL, 32'h113);
    wait_frame(cyc);
    chk_word(33'h1, {32'h0, cyc >= 4 * TL && cyc <= 4 * TL + 8});
    wr(OFS_CTRL, 32'h110);
    rd(OFS_STATUS, 33'h4);
    $display("test default frame done");
    foreach (g_addr[i])
    begin
      wr(g_addr[i], {20'h0, g_data[i]});
      rd(OFS_STATUS, {25'h0, g_stat[i]});
    end
    $display("test gating done");
    for (int i = 0; i < 6; i++)
    begin
      slow <= i[0];
      frame($urandom() & 32'h9fffffff, 4'($urandom_range(9)),
        {$urandom(), $urandom()}, i == 2, i == 4);
    end
    $display("test frames done");
    results();
  end
endmodule // tb_keepalive_sender
`default_nettype wire
